// ### rtl/pcdb_regs.vh
`ifndef PCDB_REGS_VH
`define PCDB_REGS_VH

// Word addresses of the per-axis control-data area
`define PCDB_AX1_INT_REQ   16'h049d
`define PCDB_AX1_ACCEL_LO  16'h04a0
`define PCDB_AX1_DECEL_LO  16'h04a2
`define PCDB_AX1_CHG_SEL   16'h04a4
`define PCDB_AX2_INT_REQ   16'h04cf
`define PCDB_AX2_ACCEL_LO  16'h04d2
`define PCDB_AX2_DECEL_LO  16'h04d4
`define PCDB_AX2_CHG_SEL   16'h04d6

// Offset of the upper word of a two-word time value
`define PCDB_HI_WORD_OFS   16'h0001

// Reset values
`define PCDB_RST_WORD      16'h0000
`define PCDB_RST_TIME      32'h0000_0000

// Field values
`define PCDB_VAL_ONE       16'h0001
`define PCDB_VAL_ZERO      16'h0000

`endif

// ### rtl/pcdb_bank.v
//Contract
//- Request word 1 interrupts continuous operation; resets 0
//- Module writes 0 back once request accepted
//- Accel/decel times are millisecond counts, reset 0
//- New times applied only when enable equals 1
//- Changeover flag 0 incremental, 1 absolute
//- No acceptance while not busy; start clears
`default_nettype none
`include "pcdb_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module pcdb_axis #(
  parameter [15:0] ADDR_INT = `PCDB_AX1_INT_REQ,
  parameter [15:0] ADDR_ACC = `PCDB_AX1_ACCEL_LO,
  parameter [15:0] ADDR_DEC = `PCDB_AX1_DECEL_LO,
  parameter [15:0] ADDR_SEL = `PCDB_AX1_CHG_SEL
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        wrEn,
  input  wire [15:0] addr,
  input  wire [15:0] wrData,
  input  wire        axisBusyFlag,
  input  wire        startPulse,
  input  wire        speedChange,
  output reg         hit,
  output reg  [15:0] rdWord,
  output reg         interruptPulse_reg,
  output reg  [31:0] appliedAccel_reg,
  output reg  [31:0] appliedDecel_reg,
  output reg         changeEnable_reg,
  output reg         absMode_reg
);

  reg  [15:0] intReq_reg;
  reg  [31:0] accel_reg;
  reg  [31:0] decel_reg;
  reg  [15:0] chgSel_reg;
  wire        wrInt   = wrEn && (addr == ADDR_INT);
  wire        wrAccLo = wrEn && (addr == ADDR_ACC);
  wire        wrAccHi = wrEn && (addr == ADDR_ACC + `PCDB_HI_WORD_OFS);
  wire        wrDecLo = wrEn && (addr == ADDR_DEC);
  wire        wrDecHi = wrEn && (addr == ADDR_DEC + `PCDB_HI_WORD_OFS);
  wire        wrSel   = wrEn && (addr == ADDR_SEL);
  // Only a busy axis can take the request; an idle axis leaves it pending until a start clears it
  wire        accept  = (intReq_reg == `PCDB_VAL_ONE) && axisBusyFlag;
  wire        chgOn   = (chgSel_reg == `PCDB_VAL_ONE);
  reg  [15:0] intReq_next;
  reg         interruptPulse_next;
  reg  [31:0] accel_next;
  reg  [31:0] decel_next;
  reg  [15:0] chgSel_next;
  reg  [31:0] appliedAccel_next;
  reg  [31:0] appliedDecel_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Request word: a master write in the same cycle beats the hardware clear
  always @* begin
    intReq_next         = intReq_reg;
    interruptPulse_next = accept && !startPulse;
    if (wrInt) begin
      intReq_next = wrData;
    end else if (startPulse) begin
      intReq_next = `PCDB_VAL_ZERO;
    end else if (accept) begin
      intReq_next = `PCDB_VAL_ZERO;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intReq_reg         <= `PCDB_RST_WORD;
      interruptPulse_reg <= 1'b0;
    end else begin
      intReq_reg         <= intReq_next;
      interruptPulse_reg <= interruptPulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Time words, low word first; stored as written, no range check
  always @* begin
    accel_next  = accel_reg;
    decel_next  = decel_reg;
    chgSel_next = chgSel_reg;
    if (wrAccLo) begin
      accel_next[15:0] = wrData;
    end
    if (wrAccHi) begin
      accel_next[31:16] = wrData;
    end
    if (wrDecLo) begin
      decel_next[15:0] = wrData;
    end
    if (wrDecHi) begin
      decel_next[31:16] = wrData;
    end
    if (wrSel) begin
      chgSel_next = wrData;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accel_reg  <= `PCDB_RST_TIME;
      decel_reg  <= `PCDB_RST_TIME;
      chgSel_reg <= `PCDB_RST_WORD;
    end else begin
      accel_reg  <= accel_next;
      decel_reg  <= decel_next;
      chgSel_reg <= chgSel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Speed change picks up the new times only while enabled
  always @* begin
    appliedAccel_next = appliedAccel_reg;
    appliedDecel_next = appliedDecel_reg;
    if (speedChange && chgOn) begin
      appliedAccel_next = accel_reg;
      appliedDecel_next = decel_reg;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      appliedAccel_reg <= `PCDB_RST_TIME;
      appliedDecel_reg <= `PCDB_RST_TIME;
      changeEnable_reg <= 1'b0;
      absMode_reg      <= 1'b0;
    end else begin
      changeEnable_reg <= chgOn;
      absMode_reg      <= (chgSel_reg == `PCDB_VAL_ONE);
      appliedAccel_reg <= appliedAccel_next;
      appliedDecel_reg <= appliedDecel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @* begin
    hit    = 1'b1;
    rdWord = `PCDB_VAL_ZERO;
    if (addr == ADDR_INT) begin
      rdWord = intReq_reg;
    end else if (addr == ADDR_ACC) begin
      rdWord = accel_reg[15:0];
    end else if (addr == ADDR_ACC + `PCDB_HI_WORD_OFS) begin
      rdWord = accel_reg[31:16];
    end else if (addr == ADDR_DEC) begin
      rdWord = decel_reg[15:0];
    end else if (addr == ADDR_DEC + `PCDB_HI_WORD_OFS) begin
      rdWord = decel_reg[31:16];
    end else if (addr == ADDR_SEL) begin
      rdWord = chgSel_reg;
    end else begin
      hit = 1'b0;
    end
  end

endmodule // pcdb_axis

////////////////////////////////////////////////////////////////////////////////
// Buffer-memory word port as the station sees it; bank selection happens
// upstream in the master, so only bank 0 traffic ever reaches here
module pcdb_bank (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        bufWrEn,
  input  wire        bufRdEn,
  input  wire [15:0] bufAddr,
  input  wire [15:0] bufWrData,
  input  wire [1:0]  axisBusyFlag,
  input  wire [1:0]  axisStart,
  input  wire [1:0]  speedChange,
  output reg  [15:0] bufRdData,
  output reg         bufRdValid,
  output wire [1:0]  continuousInterrupt,
  output wire [63:0] appliedAccelTime,
  output wire [63:0] appliedDecelTime,
  output wire [1:0]  accelDecelChangeEnable,
  output wire [1:0]  absolutePositioning
);

  reg         rstMeta_reg;
  reg         rstSync_reg;
  wire [1:0]  hit;
  wire [31:0] rdWord;
  reg  [15:0] bufRdData_next;

  // Release is synchronised so every flop behind rstSync_reg leaves reset on the same edge
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  pcdb_axis #(
    .ADDR_INT (`PCDB_AX1_INT_REQ),
    .ADDR_ACC (`PCDB_AX1_ACCEL_LO),
    .ADDR_DEC (`PCDB_AX1_DECEL_LO),
    .ADDR_SEL (`PCDB_AX1_CHG_SEL)
  ) axis1 (
    .clk                (sys_clk),
    .rstn               (rstSync_reg),
    .wrEn               (bufWrEn),
    .addr               (bufAddr),
    .wrData             (bufWrData),
    .axisBusyFlag       (axisBusyFlag[0]),
    .startPulse         (axisStart[0]),
    .speedChange        (speedChange[0]),
    .hit                (hit[0]),
    .rdWord             (rdWord[15:0]),
    .interruptPulse_reg (continuousInterrupt[0]),
    .appliedAccel_reg   (appliedAccelTime[31:0]),
    .appliedDecel_reg   (appliedDecelTime[31:0]),
    .changeEnable_reg   (accelDecelChangeEnable[0]),
    .absMode_reg        (absolutePositioning[0])
  );

  pcdb_axis #(
    .ADDR_INT (`PCDB_AX2_INT_REQ),
    .ADDR_ACC (`PCDB_AX2_ACCEL_LO),
    .ADDR_DEC (`PCDB_AX2_DECEL_LO),
    .ADDR_SEL (`PCDB_AX2_CHG_SEL)
  ) axis2 (
    .clk                (sys_clk),
    .rstn               (rstSync_reg),
    .wrEn               (bufWrEn),
    .addr               (bufAddr),
    .wrData             (bufWrData),
    .axisBusyFlag       (axisBusyFlag[1]),
    .startPulse         (axisStart[1]),
    .speedChange        (speedChange[1]),
    .hit                (hit[1]),
    .rdWord             (rdWord[31:16]),
    .interruptPulse_reg (continuousInterrupt[1]),
    .appliedAccel_reg   (appliedAccelTime[63:32]),
    .appliedDecel_reg   (appliedDecelTime[63:32]),
    .changeEnable_reg   (accelDecelChangeEnable[1]),
    .absMode_reg        (absolutePositioning[1])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Unmapped words read back as zero; the last answer holds between reads
  always @* begin
    bufRdData_next = bufRdData;
    if (bufRdEn) begin
      if (hit[0]) begin
        bufRdData_next = rdWord[15:0];
      end else if (hit[1]) begin
        bufRdData_next = rdWord[31:16];
      end else begin
        bufRdData_next = `PCDB_VAL_ZERO;
      end
    end
  end

  always @(posedge sys_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      bufRdData  <= `PCDB_RST_WORD;
      bufRdValid <= 1'b0;
    end else begin
      bufRdValid <= bufRdEn;
      bufRdData  <= bufRdData_next;
    end
  end

endmodule // pcdb_bank
`default_nettype wire

// ### tb/pcdb_master.sv
`default_nettype none
module pcdb_master (
  input  wire logic        sys_clk,
  input  wire logic [15:0] bufRdData,
  output var  logic        bufWrEn,
  output var  logic        bufRdEn,
  output var  logic [15:0] bufAddr,
  output var  logic [15:0] bufWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bank 0 only; idle lines show inverted data so stale values never pass
  initial begin
    bufWrEn = 1'b0;
    bufRdEn = 1'b0;
    bufAddr = 16'hffff;
    bufWrData = 16'hffff;
  end
  task automatic wr(input logic [15:0] a, d);
    @(negedge sys_clk);
    bufAddr = a;
    bufWrData = d;
    bufWrEn = 1'b1;
    @(negedge sys_clk);
    bufWrEn = 1'b0;
    bufAddr = ~a;
    bufWrData = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    bufAddr = a;
    bufRdEn = 1'b1;
    @(negedge sys_clk);
    bufRdEn = 1'b0;
    bufAddr = ~a;
    d = bufRdData;
  endtask
endmodule // pcdb_master
`default_nettype wire

// ### tb/pcdb_bank_checker.sv
`default_nettype none
module pcdb_bank_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        bufRdEn,
  input wire logic [15:0] bufAddr,
  input wire logic [1:0]  axisBusyFlag,
  input wire logic [1:0]  axisStart,
  input wire logic [1:0]  speedChange,
  input wire logic [15:0] bufRdData,
  input wire logic        bufRdValid,
  input wire logic [1:0]  continuousInterrupt,
  input wire logic [63:0] appliedAccelTime,
  input wire logic [63:0] appliedDecelTime,
  input wire logic [1:0]  accelDecelChangeEnable,
  input wire logic [1:0]  absolutePositioning
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_rd_answer: assert property (bufRdEn |=> bufRdValid) else $error("no read answer");
  chk_rd_lone: assert property (!bufRdEn |=> !bufRdValid) else $error("stray read answer");
  chk_int_busy: assert property (continuousInterrupt[0] |-> $past(axisBusyFlag[0])) else $error("idle accept");
  chk_int_start: assert property (axisStart[0] |=> !continuousInterrupt[0]) else $error("accept on start");
  chk_int_once: assert property (continuousInterrupt[0] |=> !continuousInterrupt[0]) else $error("long pulse");
  chk_mode_pair: assert property (absolutePositioning == accelDecelChangeEnable) else $error("mode split");
  chk_accel_hold: assert property (!speedChange[0] |=> $stable(appliedAccelTime[31:0])) else $error("accel moved");
  chk_decel_hold: assert property (!speedChange[1] |=> $stable(appliedDecelTime[63:32])) else $error("decel moved");
  chk_unmap_zero: assert property (bufRdEn && bufAddr == 16'h0000 |=> bufRdData == 16'h0000) else $error("unmapped");
  cover property (continuousInterrupt[0]);
  cover property (speedChange[0] ##1 appliedAccelTime[31:0] != 32'h0);
  cover property (absolutePositioning[1]);
endmodule // pcdb_bank_checker
bind pcdb_bank pcdb_bank_checker chk (.*);
`default_nettype wire

// ### tb/pcdb_bank_tb.sv
`default_nettype none
module pcdb_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rstn = 0;
  logic [1:0]  axisBusyFlag = 0, axisStart = 0, speedChange = 0;
  wire         wrEn, rdEn, rdValid;
  wire  [15:0] addr, wrData, rdData;
  wire  [1:0]  contInt, chgEn, absPos;
  wire  [63:0] accT, decT;
  logic [15:0] rv;
  int          bad_count = 0, check_count = 0, intCnt = 0;
  pcdb_bank dut (.sys_clk(sys_clk), .rstn(rstn), .bufWrEn(wrEn), .bufRdEn(rdEn), .bufAddr(addr),
    .bufWrData(wrData), .axisBusyFlag(axisBusyFlag), .axisStart(axisStart), .speedChange(speedChange),
    .bufRdData(rdData), .bufRdValid(rdValid), .continuousInterrupt(contInt), .appliedAccelTime(accT),
    .appliedDecelTime(decT), .accelDecelChangeEnable(chgEn), .absolutePositioning(absPos));
  pcdb_master m (.sys_clk(sys_clk), .bufRdData(rdData), .bufWrEn(wrEn), .bufRdEn(rdEn), .bufAddr(addr),
    .bufWrData(wrData));
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) intCnt <= intCnt + contInt[0] + contInt[1];
  task automatic chk(input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] a, exp);
    m.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20us;
    bad_count++;
    test_done;
  end
  initial begin
    cyc(12);
    rstn = 1;
    cyc(3);
    for (int o = 0; o < 16'h0064; o += 16'h0032) begin
      foreach (m.bufAddr[i]) if (i < 8) rdc(16'h049d + o + (i < 1 ? 0 : i + 2), 16'h0000);
      m.wr(16'h04a0 + o, 16'hea60);
      m.wr(16'h04a1 + o, 16'h0000);
      m.wr(16'h04a2 + o, 16'h0000);
      m.wr(16'h04a3 + o, 16'h0080);
      rdc(16'h04a0 + o, 16'hea60);
      rdc(16'h04a3 + o, 16'h0080);
    end
    $display("time words done");
    m.wr(16'h049d, 16'h0001);
    cyc(3);
    rdc(16'h049d, 16'h0001);
    chk(intCnt, 0);
    axisBusyFlag = 2'b01;
    cyc(3);
    chk(intCnt, 1);
    rdc(16'h049d, 16'h0000);
    m.wr(16'h049d, 16'h0002);
    cyc(3);
    rdc(16'h049d, 16'h0002);
    m.wr(16'h04cf, 16'h0001);
    axisStart = 2'b10;
    cyc(1);
    axisStart = 2'b00;
    rdc(16'h04cf, 16'h0000);
    chk(intCnt, 1);
    $display("interrupt done");
    m.wr(16'h04a4, 16'h0002);
    cyc(2);
    chk(absPos, 2'b00);
    speedChange = 2'b11;
    cyc(1);
    speedChange = 2'b00;
    cyc(1);
    chk(accT, 64'h0);
    m.wr(16'h04a4, 16'h0001);
    m.wr(16'h04d6, 16'h0001);
    cyc(2);
    chk({chgEn, absPos}, 4'hf);
    speedChange = 2'b11;
    cyc(1);
    speedChange = 2'b00;
    cyc(1);
    chk(accT, {2{32'h0000ea60}});
    chk(decT, {2{32'h00800000}});
    m.wr(16'h04a4, 16'h0000);
    cyc(2);
    chk(absPos, 2'b10);
    rdc(16'h0000, 16'h0000);
    $display("speed change done");
    test_done;
  end
endmodule // pcdb_bank_tb
`default_nettype wire
